// ==== src/monitor_interrupt_control.sv ====
`timescale 1ns/10ps
// configuration, limit status, masks and interrupt pins of the monitor
// assumes an 8-bit register port driven by the serial bus front end
// How it works
// - start bit runs monitoring, clear means standby
// - clearing start leaves interrupt pins unchanged
// - running enables scanning and limit checks
// - bit one enables general interrupt pin
// - bit two enables thermal interrupt pin
// - interrupt-clear bit deasserts pin, halts monitoring
// - reset bit pulses reset pin 20 ms
// - suppress bit deasserts thermal pin, keeps status
// - reinit bit restores register defaults, self clears; a running reset pulse goes on
// - configuration resets to 08h
// - limit violations set read-only status bits
// - bits zero, one flag fan/analog violation
// - second status bit four: chassis opened
// - second status bit five: external thermal pull
// - bits six, seven flag remote diode faults
// - mask bits gate status off general pin
// - thermal mask keeps thermal events off general
module monitor_interrupt_control (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  input  wire logic [7:0] limit_event_a_i,
  input  wire logic [1:0] limit_event_b_i,
  input  wire logic       chassis_open_flag_i,
  input  wire logic       thermal_alarm_n_i,
  input  wire logic       thermal_event_i,
  input  wire logic       remote_diode_a_fault_i,
  input  wire logic       remote_diode_b_fault_i,
  output logic            scan_enable_o,
  output logic            int_n_o,
  output logic            thermal_alarm_n_o,
  output logic            thermal_alarm_n_oe_o,
  output logic            reset_n_o,
  output logic            reinit_o
);
  logic [7:0] config_r;
  logic [7:0] config_nxt;
  logic [7:0] mask_a_r;
  logic [7:0] mask_b_r;
  logic       thermal_alarm_n_mask_r;
  logic       int_n_r;
  logic       thermal_alarm_n_n_r;
  logic [7:0] rdata_nxt;
  logic [7:0] status_a;
  logic [7:0] status_b;
  logic [7:0] event_a;
  logic [7:0] event_b;
  logic       wr_config;
  logic       wr_mask_a;
  logic       wr_mask_b;
  logic       wr_config2;
  logic       rd_status_a;
  logic       rd_status_b;
  logic       reinit;
  logic       running;
  logic       pulse_start;
  logic       pulse_busy;
  logic       pulse_done;
  logic [7:0] gate_b;
  logic       int_cause;
  logic       int_active;
  logic       thermal_alarm_n_active;

  assign wr_config   = reg_wr_i && (reg_addr_i == monitor_irq_pkg::OFF_CONFIG);
  assign wr_mask_a   = reg_wr_i && (reg_addr_i == monitor_irq_pkg::OFF_MASK_A);
  assign wr_mask_b   = reg_wr_i && (reg_addr_i == monitor_irq_pkg::OFF_MASK_B);
  assign wr_config2  = reg_wr_i && (reg_addr_i == monitor_irq_pkg::OFF_CONFIG2);
  assign rd_status_a = reg_rd_i
                       && (reg_addr_i == monitor_irq_pkg::OFF_STATUS_A);
  assign rd_status_b = reg_rd_i
                       && (reg_addr_i == monitor_irq_pkg::OFF_STATUS_B);

  // reinit takes effect the cycle the write lands and never reads back
  assign reinit   = wr_config
                    && reg_wdata_i[monitor_irq_pkg::CFG_REINIT];
  assign reinit_o = reinit;

  // halted while interrupt-clear is set, status is kept
  assign running = config_r[monitor_irq_pkg::CFG_START]
                   && !config_r[monitor_irq_pkg::CFG_INT_CLEAR];
  assign scan_enable_o = running;

  // limit events only count while scanning; pin-level events always do, the thermal pull only while this block is not driving the pin
  assign event_a = running ? limit_event_a_i : 8'h00;
  assign event_b = {remote_diode_b_fault_i, remote_diode_a_fault_i,
                    !thermal_alarm_n_i && !thermal_alarm_n_oe_o,
                    chassis_open_flag_i,
                    2'b00,
                    running ? limit_event_b_i : 2'b00};

  sticky_status u_status_a (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_i),
    .event_i  (event_a),
    .clear_i  (rd_status_a || reinit),
    .status_o (status_a)
  );

  sticky_status u_status_b (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_i),
    .event_i  (event_b),
    .clear_i  (rd_status_b || reinit),
    .status_o (status_b)
  );

  assign pulse_start = wr_config
                       && reg_wdata_i[monitor_irq_pkg::CFG_RESET_REQ]
                       && !reinit;

  pulse_timer u_reset_pulse (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .start_i (pulse_start),
    .busy_o  (pulse_busy),
    .done_o  (pulse_done)
  );

  assign reset_n_o = !pulse_busy;

  always_comb begin
    config_nxt = config_r;
    if (wr_config) begin
      config_nxt = reg_wdata_i & monitor_irq_pkg::CONFIG_WMASK;
      // the request bit stays up while the pulse is still running, unless reinit clears it
      config_nxt[monitor_irq_pkg::CFG_RESET_REQ] =
        reg_wdata_i[monitor_irq_pkg::CFG_RESET_REQ] || pulse_busy;
      config_nxt[monitor_irq_pkg::CFG_REINIT] = 1'b0;
    end
    if (pulse_done) begin
      config_nxt[monitor_irq_pkg::CFG_RESET_REQ] = 1'b0;
    end
    if (reinit) begin
      config_nxt = monitor_irq_pkg::CONFIG_RESET;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      config_r <= monitor_irq_pkg::CONFIG_RESET;
    end else begin
      config_r <= config_nxt;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask_a_r     <= monitor_irq_pkg::MASK_RESET;
      mask_b_r     <= monitor_irq_pkg::MASK_RESET;
      thermal_alarm_n_mask_r <= 1'b0;
    end else if (reinit) begin
      mask_a_r     <= monitor_irq_pkg::MASK_RESET;
      mask_b_r     <= monitor_irq_pkg::MASK_RESET;
      thermal_alarm_n_mask_r <= 1'b0;
    end else begin
      if (wr_mask_a) mask_a_r <= reg_wdata_i;
      if (wr_mask_b) mask_b_r <= reg_wdata_i;
      if (wr_config2) begin
        thermal_alarm_n_mask_r <= reg_wdata_i[monitor_irq_pkg::CFG2_THERMAL_ALARM_N_MASK];
      end
    end
  end

  // thermal mask removes thermal sources from the general pin only
  assign gate_b = ~mask_b_r
                  & ~(thermal_alarm_n_mask_r ? monitor_irq_pkg::STATUS_B_THERMAL
                                   : 8'h00);
  assign int_cause = |(status_a & ~mask_a_r) | |(status_b & gate_b);
  // the start bit plays no part here, so clearing it keeps the pins
  assign int_active = config_r[monitor_irq_pkg::CFG_INT_EN]
                      && !config_r[monitor_irq_pkg::CFG_INT_CLEAR]
                      && int_cause;
  assign thermal_alarm_n_active = config_r[monitor_irq_pkg::CFG_THERMAL_ALARM_N_EN]
                        && !config_r[monitor_irq_pkg::CFG_THERMAL_ALARM_N_SUPP]
                        && thermal_event_i;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      int_n_r   <= 1'b1;
      thermal_alarm_n_n_r <= 1'b1;
    end else begin
      int_n_r   <= !int_active;
      thermal_alarm_n_n_r <= !thermal_alarm_n_active;
    end
  end

  assign int_n_o              = int_n_r;
  // open drain: only ever pulls low
  assign thermal_alarm_n_o    = 1'b0;
  assign thermal_alarm_n_oe_o = !thermal_alarm_n_n_r;

  always_comb begin
    unique case (reg_addr_i)
      monitor_irq_pkg::OFF_CONFIG:   rdata_nxt = config_r;
      monitor_irq_pkg::OFF_STATUS_A: rdata_nxt = status_a;
      monitor_irq_pkg::OFF_STATUS_B: rdata_nxt = status_b;
      monitor_irq_pkg::OFF_MASK_A:   rdata_nxt = mask_a_r;
      monitor_irq_pkg::OFF_MASK_B:   rdata_nxt = mask_b_r;
      monitor_irq_pkg::OFF_CONFIG2:  rdata_nxt = {7'h00, thermal_alarm_n_mask_r};
      default:                       rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_nxt;
    end
  end

  chk_reset_default: assert property (
    @(posedge clk_i) $rose(rst_n_i) |-> config_r == 8'h08)
    else $error("config not 08h after reset");

  // every limit_event_a_i bit seen while scanning must be latched in the first status register
  chk_start_scan: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    scan_enable_o
    |=> (status_a & $past(limit_event_a_i)) == $past(limit_event_a_i))
    else $error("limit event lost while scanning");

  chk_standby_hold: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (!scan_enable_o && status_a == 8'h00) |=> status_a == 8'h00)
    else $error("limit status set while in standby");

  chk_int_enable: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    !config_r[1] |=> int_n_o)
    else $error("general pin active while disabled");

  chk_int_clear: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    config_r[3] |-> !scan_enable_o ##1 int_n_o)
    else $error("interrupt clear not honoured");

  chk_thermal_alarm_n_enable: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (!config_r[2] || config_r[6]) |=> !thermal_alarm_n_oe_o)
    else $error("thermal pin driven while disabled or suppressed");

  chk_int_assert: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (config_r[1] && !config_r[3] && |(status_a & ~mask_a_r)) |=> !int_n_o)
    else $error("general pin not asserted for unmasked status");

  chk_mask_gate: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (status_b == 8'h00 && (status_a & ~mask_a_r) == 8'h00) |=> int_n_o)
    else $error("masked status reached general pin");

  sequence reset_req_s;
    wr_config && reg_wdata_i[4] && !reg_wdata_i[7] && !pulse_busy;
  endsequence

  chk_reset_pulse: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    reset_req_s |=> !reset_n_o [*8])
    else $error("reset pulse shorter than expected");

  chk_reinit_all: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    // an event in the reinit cycle is kept, so only quiet cycles count
    (reinit && limit_event_a_i == 8'h00)
    |=> config_r == 8'h08 && mask_a_r == 8'h00
               && status_a == 8'h00 && !config_r[7])
    else $error("reinit did not restore defaults");

  chk_status_sticky: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (status_a[0] && !rd_status_a && !reinit) |=> status_a[0])
    else $error("status bit dropped without read");
endmodule

// ==== inc/monitor_irq_pkg.sv ====
// constants for the monitor control and interrupt block
// assumes one 250 mhz clock and an 8-bit register port from the bus slave
package monitor_irq_pkg;
  localparam logic [7:0] OFF_CONFIG   = 8'h40;
  localparam logic [7:0] OFF_STATUS_A = 8'h41;
  localparam logic [7:0] OFF_STATUS_B = 8'h42;
  localparam logic [7:0] OFF_MASK_A   = 8'h43;
  localparam logic [7:0] OFF_MASK_B   = 8'h44;
  localparam logic [7:0] OFF_CONFIG2  = 8'h4a;

  localparam logic [7:0] CONFIG_RESET = 8'h08;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET   = 8'h00;
  localparam logic [7:0] CONFIG_WMASK = 8'hdf;

  localparam int CFG_START      = 0;
  localparam int CFG_INT_EN     = 1;
  localparam int CFG_THERMAL_ALARM_N_EN   = 2;
  localparam int CFG_INT_CLEAR  = 3;
  localparam int CFG_RESET_REQ  = 4;
  localparam int CFG_THERMAL_ALARM_N_SUPP = 6;
  localparam int CFG_REINIT     = 7;
  localparam int CFG2_THERMAL_ALARM_N_MASK = 0;

  // thermal-type status bit of the second status register
  localparam logic [7:0] STATUS_B_THERMAL = 8'h20;
  localparam logic [7:0] STATUS_B_RSVD    = 8'h0c;

  // reset pulse: 20 ms least, rounded up in 4 ns cycles
  localparam int CLK_PERIOD_PS   = 4000;
  localparam int RESET_PULSE_MS  = 20;
  localparam longint RESET_PULSE_PS = 64'd1000000000 * RESET_PULSE_MS;
  localparam int RESET_PULSE_CYC =
    int'((RESET_PULSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
endpackage

// ==== src/sticky_status.sv ====
`timescale 1ns/10ps
// one sticky status register: set by events, cleared on read or reinit
// assumes events are synchronous single-cycle or level strobes
module sticky_status (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [7:0] event_i,
  input  wire logic       clear_i,
  output logic      [7:0] status_o
);
  logic [7:0] status_nxt;

  // an event in the clearing cycle survives the clear
  assign status_nxt = (clear_i ? monitor_irq_pkg::STATUS_RESET : status_o)
                      | event_i;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_o <= monitor_irq_pkg::STATUS_RESET;
    end else begin
      status_o <= status_nxt;
    end
  end
endmodule

// ==== src/pulse_timer.sv ====
`timescale 1ns/10ps
// fixed-length active pulse generator for the reset output
// assumes start_i is a one-cycle request; ignored while busy
module pulse_timer #(
  parameter int LENGTH = monitor_irq_pkg::RESET_PULSE_CYC
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic start_i,
  output logic      busy_o,
  output logic      done_o
);
  logic [31:0] count_r;
  logic [31:0] count_nxt;
  logic        last;

  assign last      = busy_o && (count_r == 32'(LENGTH - 1));
  assign count_nxt = busy_o ? count_r + 32'h1 : 32'h0;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_o  <= 1'b0;
      done_o  <= 1'b0;
      count_r <= 32'h0;
    end else begin
      done_o  <= last;
      count_r <= last ? 32'h0 : count_nxt;
      if (last) begin
        busy_o <= 1'b0;
      end else if (start_i) begin
        busy_o <= 1'b1;
      end
    end
  end
endmodule

// ==== test/host_model.sv ====
// host side of the monitor register port: one-cycle write and read strobes
// assumes one caller at a time; lines change only at falling edges
`timescale 1ns/10ps
module host_model (
  input  wire logic       clk_i,
  output logic      [7:0] reg_addr_o,
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic      [7:0] reg_wdata_o
);
  initial begin
    reg_addr_o  = 8'h00;
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_wdata_o = 8'h00;
  end

  // released address and data lines are inverted so a stale address never looks valid
  task automatic drive(input logic [7:0] a, input logic [7:0] d,
                       input logic w);
    @(negedge clk_i);
    reg_addr_o  = a;
    reg_wdata_o = d;
    reg_wr_o    = w;
    reg_rd_o    = !w;
    @(negedge clk_i);
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_addr_o  = ~a;
    reg_wdata_o = ~d;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    drive(a, d, 1'b1);
  endtask

  task automatic rd(input logic [7:0] a);
    drive(a, 8'h00, 1'b0);
  endtask
endmodule

// ==== test/monitor_interrupt_control_tb.sv ====
// self-checking bench for the monitor control and interrupt block
// assumes the host model drives the register port; pulse end not reached
`timescale 1ns/10ps
module monitor_interrupt_control_tb;
  logic       clk_i   = 1'b0;
  logic       rst_n_i = 1'b0;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, limit_event_a_i, rnd;
  logic       reg_wr_i, reg_rd_i, rd_q;
  logic [1:0] limit_event_b_i;
  logic       chassis_open_flag_i, thermal_event_i, ext_pull_n;
  logic       remote_diode_a_fault_i, remote_diode_b_fault_i;
  logic       scan_enable_o, int_n_o, thermal_alarm_n_o;
  logic       thermal_alarm_n_oe_o, reset_n_o, reinit_o, thermal_alarm_n_i;
  logic [7:0] exp_q[$];
  int         mismatches, samples_checked, cycles, seed;

  always #2 clk_i = ~clk_i;
  // pin has a pull-up; either party may pull it low
  assign thermal_alarm_n_i =
    (thermal_alarm_n_oe_o ? thermal_alarm_n_o : 1'b1) & ext_pull_n;

  monitor_interrupt_control u_dut (
    .clk_i, .rst_n_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
    .reg_rdata_o, .limit_event_a_i, .limit_event_b_i, .chassis_open_flag_i,
    .thermal_alarm_n_i, .thermal_event_i, .remote_diode_a_fault_i,
    .remote_diode_b_fault_i, .scan_enable_o, .int_n_o, .thermal_alarm_n_o,
    .thermal_alarm_n_oe_o, .reset_n_o, .reinit_o
  );
  host_model u_host (
    .clk_i, .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
    .reg_rd_o(reg_rd_i), .reg_wdata_o(reg_wdata_i)
  );

  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t pin %b expected %b", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_host.rd(a);
  endtask

  task automatic settle();
    repeat (2) @(negedge clk_i);
  endtask

  // s holds chassis, diode a, diode b
  task automatic pulse_ev(input logic [7:0] a, input logic [1:0] b,
                          input logic [2:0] s);
    @(negedge clk_i);
    limit_event_a_i = a;
    limit_event_b_i = b;
    {chassis_open_flag_i, remote_diode_a_fault_i, remote_diode_b_fault_i} = s;
    @(negedge clk_i);
    limit_event_a_i = 8'h00;
    limit_event_b_i = 2'b00;
    {chassis_open_flag_i, remote_diode_a_fault_i, remote_diode_b_fault_i} = '0;
    settle();
  endtask

  task automatic pull_ext();
    @(negedge clk_i);
    ext_pull_n = 1'b0;
    @(negedge clk_i);
    ext_pull_n = 1'b1;
    settle();
  endtask

  // read data is valid in the cycle after the read strobe is taken
  always @(posedge clk_i) begin
    rd_q <= reg_rd_i;
    cycles++;
    if (reg_wr_i && reg_addr_i == 8'h40) chk_pin(reinit_o, reg_wdata_i[7]);
    if (cycles == 3000) begin
      mismatches++;
      conclude();
    end
  end
  always @(negedge clk_i) begin
    if (rd_q) chk_rd(reg_rdata_o, exp_q.pop_front());
  end

  initial begin
    {mismatches, samples_checked, cycles, seed} = {32'd0, 32'd0, 32'd0, 32'd79};
    rd_q = 1'b0;
    {limit_event_a_i, limit_event_b_i, ext_pull_n, thermal_event_i} = 12'h002;
    {chassis_open_flag_i, remote_diode_a_fault_i, remote_diode_b_fault_i} = '0;
    repeat (6) @(negedge clk_i);
    rst_n_i = 1'b1;
    chk_pin(int_n_o, 1'b1);
    chk_pin(scan_enable_o, 1'b0);
    for (int i = 0; i < 7; i++) rd_chk(8'h40 + 8'(i), i == 0 ? 8'h08 : 8'h00);
    for (int i = 0; i < 2; i++) begin
      rnd = 8'($random(seed));
      u_host.wr(8'h43 + 8'(i), rnd);
      rd_chk(8'h43 + 8'(i), rnd);
      u_host.wr(8'h43 + 8'(i), 8'h00);
    end
    u_host.wr(8'h40, 8'h03);
    chk_pin(scan_enable_o, 1'b1);
    for (int i = 0; i < 8; i++) begin
      pulse_ev(8'h01 << i, 2'b00, 3'b000);
      chk_pin(int_n_o, 1'b0);
      rd_chk(8'h41, 8'h01 << i);
      settle();
      chk_pin(int_n_o, 1'b1);
    end
    rnd = 8'($random(seed)) | 8'h01;
    pulse_ev(rnd, 2'b00, 3'b000);
    u_host.wr(8'h40, 8'h02);
    chk_pin(scan_enable_o, 1'b0);
    settle();
    chk_pin(int_n_o, 1'b0);
    // standby: limit events must not reach either status register
    pulse_ev(8'hff, 2'b11, 3'b000);
    rd_chk(8'h41, rnd);
    u_host.wr(8'h40, 8'h03);
    u_host.wr(8'h43, 8'hff);
    pulse_ev(8'h10, 2'b00, 3'b000);
    chk_pin(int_n_o, 1'b1);
    u_host.wr(8'h43, 8'h00);
    settle();
    chk_pin(int_n_o, 1'b0);
    u_host.wr(8'h40, 8'h2b);
    settle();
    chk_pin(int_n_o, 1'b1);
    chk_pin(scan_enable_o, 1'b0);
    rd_chk(8'h40, 8'h0b);
    rd_chk(8'h41, 8'h10);
    u_host.wr(8'h40, 8'h03);
    rnd = 8'($random(seed));
    pulse_ev(8'h00, rnd[1:0], 3'b111);
    rd_chk(8'h42, 8'hd0 | {6'h00, rnd[1:0]});
    u_host.wr(8'h40, 8'h07);
    thermal_event_i = 1'b1;
    settle();
    chk_pin(thermal_alarm_n_oe_o, 1'b1);
    chk_pin(thermal_alarm_n_o, 1'b0);
    u_host.wr(8'h40, 8'h47);
    settle();
    chk_pin(thermal_alarm_n_oe_o, 1'b0);
    u_host.wr(8'h40, 8'h03);
    settle();
    chk_pin(thermal_alarm_n_oe_o, 1'b0);
    thermal_event_i = 1'b0;
    u_host.wr(8'h4a, 8'h01);
    rd_chk(8'h4a, 8'h01);
    pull_ext();
    chk_pin(int_n_o, 1'b1);
    rd_chk(8'h42, 8'h20);
    u_host.wr(8'h4a, 8'h00);
    pull_ext();
    chk_pin(int_n_o, 1'b0);
    u_host.wr(8'h43, 8'h5a);
    u_host.wr(8'h40, 8'h13);
    chk_pin(reset_n_o, 1'b0);
    repeat (100) @(negedge clk_i);
    chk_pin(reset_n_o, 1'b0);
    rd_chk(8'h40, 8'h13);
    u_host.wr(8'h40, 8'h80);
    rd_chk(8'h40, 8'h08);
    rd_chk(8'h43, 8'h00);
    rd_chk(8'h42, 8'h00);
    settle();
    chk_pin(int_n_o, 1'b1);
    conclude();
  end
endmodule
